// ---- logic/fsp_bus_cycle.sv ----
// one asynchronous flash read or write cycle, strobes paced from mclk
`timescale 1ns/10ps
`include "fsp_cfg.svh"
module fsp_bus_cycle
  import fsp_pkg::*;
(
  // clock and reset
  input  wire logic               mclk,
  input  wire logic               reset,
  // request from the sequencer
  input  wire logic               req,
  input  wire logic               wr,
  input  wire logic [`FSP_AW-1:0] addr,
  input  wire logic [`FSP_DW-1:0] wdata,
  output logic                    done,
  output logic      [`FSP_DW-1:0] rdata,
  // flash pins
  output logic                    ce_n,
  output logic                    oe_n,
  output logic                    we_n,
  output logic      [`FSP_AW-1:0] faddr,
  output logic      [`FSP_DW-1:0] dq_o,
  output logic                    dq_oe_n,
  input  wire logic [`FSP_DW-1:0] dq_i
);
  fsp_bus_e           st_r, st_nxt;
  logic [7:0]         cnt_r, cnt_nxt;
  logic               wr_r, wr_nxt;
  logic               ce_n_nxt, oe_n_nxt, we_n_nxt, dq_oe_n_nxt, done_nxt;
  logic [`FSP_AW-1:0] faddr_nxt;
  logic [`FSP_DW-1:0] dq_o_nxt, rdata_nxt;
  logic [`FSP_DW-1:0] dq_s1_r, dq_s2_r;

  // ==================================================================
  // cycle sequencing; after a read the END state keeps every strobe high for a cycle so
  // two successive reads are always two distinct output-enable pulses
  always_comb
  begin
    st_nxt      = st_r;
    cnt_nxt     = cnt_r;
    wr_nxt      = wr_r;
    ce_n_nxt    = ce_n;
    oe_n_nxt    = oe_n;
    we_n_nxt    = we_n;
    dq_oe_n_nxt = dq_oe_n;
    faddr_nxt   = faddr;
    dq_o_nxt    = dq_o;
    rdata_nxt   = rdata;
    done_nxt    = 1'b0;
    case (st_r)
      B_IDLE:
      begin
        if (req)
        begin
          st_nxt      = B_SETUP;
          wr_nxt      = wr;
          faddr_nxt   = addr;
          dq_o_nxt    = wdata;
          ce_n_nxt    = 1'b0;
          dq_oe_n_nxt = ~wr;
        end
      end
      B_SETUP:
      begin
        st_nxt   = B_ACT;
        oe_n_nxt = wr_r;
        we_n_nxt = ~wr_r;
        // reads wait the access time plus the synchroniser latency
        cnt_nxt  = wr_r ? 8'(`FSP_WP_CYC) : 8'(`FSP_RD_CYC + `FSP_SYNC_CYC);
      end
      B_ACT:
      begin
        if (cnt_r == 8'h01)
        begin
          st_nxt   = B_END;
          done_nxt = 1'b1;
          we_n_nxt = 1'b1;
          oe_n_nxt = 1'b1;
          if (!wr_r)
          begin
            rdata_nxt = dq_s2_r;
            ce_n_nxt  = 1'b1;
          end
        end
        else
        begin
          cnt_nxt = cnt_r - 8'h01;
        end
      end
      B_END:
      begin
        st_nxt      = B_IDLE;
        ce_n_nxt    = 1'b1;
        dq_oe_n_nxt = 1'b1;   // data held one cycle past the write strobe rise
      end
      default:
      begin
        st_nxt = B_IDLE;
      end
    endcase
  end

  // ==================================================================
  // pin data enters through two flops before it is captured
  always_ff @(posedge mclk)
  begin
    dq_s1_r <= dq_i;
    dq_s2_r <= dq_s1_r;
  end

  // state and pin flops
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      st_r    <= B_IDLE;
      cnt_r   <= 8'h00;
      wr_r    <= 1'b0;
      ce_n    <= 1'b1;
      oe_n    <= 1'b1;
      we_n    <= 1'b1;
      dq_oe_n <= 1'b1;
      faddr   <= '0;
      dq_o    <= '0;
      rdata   <= '0;
      done    <= 1'b0;
    end
    else
    begin
      st_r    <= st_nxt;
      cnt_r   <= cnt_nxt;
      wr_r    <= wr_nxt;
      ce_n    <= ce_n_nxt;
      oe_n    <= oe_n_nxt;
      we_n    <= we_n_nxt;
      dq_oe_n <= dq_oe_n_nxt;
      faddr   <= faddr_nxt;
      dq_o    <= dq_o_nxt;
      rdata   <= rdata_nxt;
      done    <= done_nxt;
    end
  end
endmodule : fsp_bus_cycle

// ---- logic/fsp_cfg.svh ----
// constants for the flash status polling host controller
`ifndef FSP_CFG_SVH
`define FSP_CFG_SVH

// ==================================================================
// widths and timing
`define FSP_DW          16
`define FSP_AW          26
`define FSP_LINE_SHIFT  4
`define FSP_CLK_NS      100
`define FSP_T_RD_NS     100
`define FSP_T_WP_NS     100
`define FSP_T_RECOV_NS  2000
`define FSP_SYNC_CYC    2
`define FSP_RD_CYC      ((`FSP_T_RD_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)
`define FSP_WP_CYC      ((`FSP_T_WP_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)
`define FSP_RECOV_CYC   ((`FSP_T_RECOV_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)

// ==================================================================
// status word bits and mask of defined bits
`define FSP_DQ_TOGGLE   6
`define FSP_DQ_TIMEOUT  5
`define FSP_DQ_ERASE    3
`define FSP_DQ_ABORT    1
`define FSP_STAT_MASK   16'h00EE

// ==================================================================
// register byte offsets and control fields
`define FSP_OFS_CTRL    8'h00
`define FSP_OFS_ADDR    8'h04
`define FSP_OFS_WDATA   8'h08
`define FSP_OFS_STAT    8'h0C
`define FSP_OFS_RDATA   8'h10
`define FSP_OFS_RSTCMD  8'h14
`define FSP_OFS_SUSP    8'h18
`define FSP_CTRL_GO     0
`define FSP_CTRL_OP_HI  3
`define FSP_CTRL_OP_LO  1
`define FSP_SUSP_VALID  31

`endif

// ---- logic/fsp_host.sv ----
// flash status polling host: apb registers, toggle polling sequencer, flash pins
//
// The register offsets and register access over APB were left to the implementer.
`timescale 1ns/10ps
`include "fsp_cfg.svh"
module fsp_host
  import fsp_pkg::*;
(
  // clock and reset
  input  wire logic               mclk,
  input  wire logic               reset,
  // apb slave
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  // flash pins
  output logic                    flash_ce_n,
  output logic                    flash_oe_n,
  output logic                    flash_we_n,
  output logic      [`FSP_AW-1:0] flash_addr,
  output logic      [`FSP_DW-1:0] flash_dq_o,
  output logic                    flash_dq_oe_n,
  input  wire logic [`FSP_DW-1:0] flash_dq_i,
  input  wire logic               ready_busy_output
);
  localparam int RECOV_CYC = `FSP_RECOV_CYC;
  fsp_hst_e           st_r, st_nxt;
  fsp_op_e            op_r;
  fsp_res_e           res_r, res_nxt;
  logic [`FSP_AW-1:0] addr_r, susp_addr_r;
  logic [`FSP_DW-1:0] wdata_r, rstcmd_r, rdata_r, rdata_nxt, stat_r, stat_nxt;
  logic [`FSP_DW-1:0] prev_r, prev_nxt, bus_rdata, bus_wdata;
  logic               susp_valid_r, erase_begun_r, erase_begun_nxt;
  logic [7:0]         cnt_r, cnt_nxt;
  logic               issue_r, issue_nxt, wr_r, wr_nxt, bus_done;
  logic               rb_s1_r, rb_s2_r;
  logic [2:0]         rd_cnt_r;

  // ==================================================================
  // apb decode; answer one cycle into the access phase
  wire apb_acc   = psel & penable & ~pready;
  wire apb_take  = psel & penable & pready;
  wire apb_wr    = apb_take & pwrite;
  wire idle      = (st_r == H_IDLE);
  wire hit_ctrl  = (paddr == `FSP_OFS_CTRL);
  wire hit_addr  = (paddr == `FSP_OFS_ADDR);
  wire hit_wdata = (paddr == `FSP_OFS_WDATA);
  wire hit_stat  = (paddr == `FSP_OFS_STAT);
  wire hit_rdata = (paddr == `FSP_OFS_RDATA);
  wire hit_rst   = (paddr == `FSP_OFS_RSTCMD);
  wire hit_susp  = (paddr == `FSP_OFS_SUSP);
  wire hit_any   = hit_ctrl | hit_addr | hit_wdata | hit_stat | hit_rdata | hit_rst | hit_susp;
  wire launch    = apb_wr & hit_ctrl & pwdata[`FSP_CTRL_GO] & idle;
  wire fsp_op_e  launch_op = fsp_op_e'(pwdata[`FSP_CTRL_OP_HI:`FSP_CTRL_OP_LO]);
  // status word view and read mux
  wire [31:0] stat_word = {8'h00, stat_r, 2'h0, rb_s2_r, erase_begun_r, res_r, ~idle};
  wire [31:0] rd_mux    = hit_ctrl  ? {29'h0, op_r} :
                          hit_addr  ? {6'h00, addr_r} :
                          hit_wdata ? {16'h0000, wdata_r} :
                          hit_stat  ? stat_word :
                          hit_rdata ? {16'h0000, rdata_r} :
                          hit_rst   ? {16'h0000, rstcmd_r} :
                          hit_susp  ? {susp_valid_r, 5'h00, susp_addr_r} : 32'h0000_0000;
  // poll decisions on the word just read against the one before
  wire toggling = bus_rdata[`FSP_DQ_TOGGLE] ^ prev_r[`FSP_DQ_TOGGLE];
  wire in_susp  = susp_valid_r &
                  (addr_r[`FSP_AW-1:`FSP_LINE_SHIFT] == susp_addr_r[`FSP_AW-1:`FSP_LINE_SHIFT]);
  // states that run a flash cycle
  function automatic logic cyc_state(input fsp_hst_e s);
    cyc_state = (s == H_CYCLE) | (s == H_RD1) | (s == H_RD2) | (s == H_RD3) | (s == H_RST);
  endfunction : cyc_state

  // ==================================================================
  // sequencer: single cycles, toggle polling, timeout reset and recovery
  always_comb
  begin
    st_nxt          = st_r;
    res_nxt         = res_r;
    rdata_nxt       = rdata_r;
    stat_nxt        = stat_r;
    prev_nxt        = prev_r;
    erase_begun_nxt = erase_begun_r;
    cnt_nxt         = cnt_r;
    case (st_r)
      H_IDLE:
      begin
        if (launch)
        begin
          res_nxt = RES_NONE;
          if (launch_op == OP_WRITE)
            st_nxt = H_CYCLE;
          else if (in_susp)
            res_nxt = RES_REFUSED;
          else if (launch_op == OP_READ)
            st_nxt = H_CYCLE;
          else
          begin
            st_nxt          = H_RD1;
            erase_begun_nxt = 1'b0;
          end
        end
      end
      H_CYCLE:
      begin
        if (bus_done)
        begin
          st_nxt  = H_IDLE;
          res_nxt = RES_PASS;
          if (op_r == OP_READ)
            rdata_nxt = bus_rdata;
        end
      end
      H_RD1:
      begin
        if (bus_done)
        begin
          st_nxt   = H_RD2;
          prev_nxt = bus_rdata;
        end
      end
      H_RD2:
      begin
        if (bus_done)
        begin
          st_nxt   = H_IDLE;
          prev_nxt = bus_rdata;
          stat_nxt = bus_rdata & `FSP_STAT_MASK;
          if (op_r == OP_ERASE_CHK)
          begin
            // only a toggling word proves the erase command was taken
            res_nxt         = toggling ? RES_BUSY : RES_NOT_ACCEPTED;
            erase_begun_nxt = toggling & bus_rdata[`FSP_DQ_ERASE];
          end
          else if (!toggling)
            res_nxt = RES_PASS;
          else if (bus_rdata[`FSP_DQ_ABORT])
            res_nxt = RES_ABORT;
          else if (bus_rdata[`FSP_DQ_TIMEOUT])
            st_nxt = H_RD3;
          else
            res_nxt = RES_BUSY;
        end
      end
      H_RD3:
      begin
        if (bus_done)
        begin
          stat_nxt = bus_rdata & `FSP_STAT_MASK;
          // toggling may have stopped just as the timeout bit rose
          st_nxt   = toggling ? H_RST : H_IDLE;
          res_nxt  = toggling ? res_r : RES_PASS;
        end
      end
      H_RST:
      begin
        if (bus_done)
        begin
          st_nxt  = H_RECOV;
          cnt_nxt = 8'(`FSP_RECOV_CYC);
        end
      end
      H_RECOV:
      begin
        // the part may still look busy for a while after the reset write
        if (cnt_r == 8'h01)
        begin
          st_nxt  = H_IDLE;
          res_nxt = RES_TIMEOUT;
        end
        else
          cnt_nxt = cnt_r - 8'h01;
      end
      default:
      begin
        st_nxt = H_IDLE;
      end
    endcase
  end

  // a cycle request goes out on entry to, or on completion within, a cycle state
  always_comb
  begin
    issue_nxt = cyc_state(st_nxt) & (idle | bus_done);
    wr_nxt    = (st_nxt == H_RST) | ((st_nxt == H_CYCLE) & (op_r == OP_WRITE));
    if (idle & launch)
      wr_nxt = (launch_op == OP_WRITE);
  end
  // reset command goes to the poll address, which stays valid for the operation
  assign bus_wdata = (st_r == H_RST || st_nxt == H_RST) ? rstcmd_r : wdata_r;
  // ==================================================================
  // sequencer flops
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      st_r          <= H_IDLE;
      res_r         <= RES_NONE;
      rdata_r       <= '0;
      stat_r        <= '0;
      prev_r        <= '0;
      erase_begun_r <= 1'b0;
      cnt_r         <= 8'h00;
      issue_r       <= 1'b0;
      wr_r          <= 1'b0;
    end
    else
    begin
      st_r          <= st_nxt;
      res_r         <= res_nxt;
      rdata_r       <= rdata_nxt;
      stat_r        <= stat_nxt;
      prev_r        <= prev_nxt;
      erase_begun_r <= erase_begun_nxt;
      cnt_r         <= cnt_nxt;
      issue_r       <= issue_nxt;
      wr_r          <= wr_nxt;
    end
  end

  // software registers; address and data are frozen while an operation runs
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      op_r         <= OP_WRITE;
      addr_r       <= '0;
      wdata_r      <= '0;
      rstcmd_r     <= '0;
      susp_addr_r  <= '0;
      susp_valid_r <= 1'b0;
    end
    else if (apb_wr & idle)
    begin
      if (launch)
        op_r <= launch_op;
      if (hit_addr)
        addr_r <= pwdata[`FSP_AW-1:0];
      if (hit_wdata)
        wdata_r <= pwdata[`FSP_DW-1:0];
      if (hit_rst)
        rstcmd_r <= pwdata[`FSP_DW-1:0];
      if (hit_susp)
      begin
        susp_addr_r  <= pwdata[`FSP_AW-1:0];
        susp_valid_r <= pwdata[`FSP_SUSP_VALID];
      end
    end
  end

  // apb answer flops
  always_ff @(posedge mclk)
  begin
    if (reset)
    begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end
    else
    begin
      pready  <= apb_acc;
      pslverr <= apb_acc & ~hit_any;
      prdata  <= (apb_acc & ~pwrite) ? rd_mux : 32'h0000_0000;
    end
  end

  // ready/busy pin is only reported, after two flops
  always_ff @(posedge mclk)
  begin
    rb_s1_r <= ready_busy_output;
    rb_s2_r <= rb_s1_r;
  end

  // ==================================================================
  // flash cycle engine
  fsp_bus_cycle u_cycle (
    .mclk    (mclk),
    .reset   (reset),
    .req     (issue_r),
    .wr      (wr_r),
    .addr    (addr_r),
    .wdata   (bus_wdata),
    .done    (bus_done),
    .rdata   (bus_rdata),
    .ce_n    (flash_ce_n),
    .oe_n    (flash_oe_n),
    .we_n    (flash_we_n),
    .faddr   (flash_addr),
    .dq_o    (flash_dq_o),
    .dq_oe_n (flash_dq_oe_n),
    .dq_i    (flash_dq_i)
  );

  // ==================================================================
  // checks; reads counted since the last launch of any operation
  always_ff @(posedge mclk)
  begin
    if (reset | launch)
      rd_cnt_r <= 3'h0;
    else if (bus_done & ~wr_r & (rd_cnt_r != 3'h7))
      rd_cnt_r <= rd_cnt_r + 3'h1;
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (reset);
  chk_poll_two_reads: assert property (
    (st_r == H_RD2 && st_nxt == H_IDLE && op_r != OP_READ) |=> rd_cnt_r >= 3'h2)
    else $error("poll ended before two reads");
  chk_recheck_dq5: assert property (
    $rose(st_r == H_RST) |-> rd_cnt_r >= 3'h3 && $past(st_r) == H_RD3)
    else $error("reset issued without recheck");
  chk_reset_write: assert property (
    (st_r == H_RD3 && bus_done && toggling) |=> ##[1:12] (!flash_we_n && flash_dq_o == rstcmd_r))
    else $error("reset command not written");
  chk_timeout_wait: assert property (
    (st_r == H_RST && bus_done) |=> (st_r == H_RECOV)[*8] ##[1:RECOV_CYC] res_r == RES_TIMEOUT)
    else $error("timeout result out of time");
  chk_erase_dq3: assert property (
    $rose(erase_begun_r) |-> op_r == OP_ERASE_CHK && rd_cnt_r >= 3'h2 && $changed(prev_r[`FSP_DQ_TOGGLE]))
    else $error("erase start taken without toggle check");
  chk_restart_poll: assert property (
    (launch && launch_op >= OP_POLL && !in_susp) |=> st_r == H_RD1 && rd_cnt_r == 3'h0)
    else $error("poll did not restart");
  chk_abort_seen: assert property (
    $rose(res_r == RES_ABORT) |-> prev_r[`FSP_DQ_ABORT] && stat_r[`FSP_DQ_ABORT])
    else $error("abort reported without bit 1");
  chk_no_susp_read: assert property (
    (issue_r && !wr_r) |-> !in_susp) else $error("read issued in suspended line");
  chk_status_addr: assert property (
    $fell(flash_oe_n) |-> flash_addr == addr_r && !flash_ce_n && flash_we_n)
    else $error("status read at wrong address");

  cov_pass: cover property ($rose(res_r == RES_PASS) && op_r == OP_POLL);
  cov_timeout: cover property ($rose(res_r == RES_TIMEOUT));
  cov_abort: cover property ($rose(res_r == RES_ABORT));
endmodule : fsp_host

// ---- logic/fsp_pkg.sv ----
// types shared by the flash status polling host controller
package fsp_pkg;
  typedef enum logic [2:0] {OP_WRITE, OP_READ, OP_POLL, OP_ERASE_CHK} fsp_op_e;
  typedef enum logic [2:0] {RES_NONE, RES_PASS, RES_BUSY, RES_TIMEOUT,
                            RES_ABORT, RES_NOT_ACCEPTED, RES_REFUSED} fsp_res_e;
  typedef enum logic [2:0] {H_IDLE, H_CYCLE, H_RD1, H_RD2, H_RD3, H_RST, H_RECOV} fsp_hst_e;
  typedef enum logic [1:0] {B_IDLE, B_SETUP, B_ACT, B_END} fsp_bus_e;
endpackage : fsp_pkg

// ---- logic/fsp_spare_unused.sv ----
// spare design file; the block needs no third module, so this holds no logic
`timescale 1ns/10ps

// ---- sim/fsp_flash_model.sv ----
// behavioural flash device answering host reads with array data or polling status
`timescale 1ns/10ps
`include "fsp_cfg.svh"
module fsp_flash_model #(parameter int SECT_SHIFT = 16)
(
  // flash strobes and address
  input  wire logic               ce_n,
  input  wire logic               oe_n,
  input  wire logic               we_n,
  input  wire logic [`FSP_AW-1:0] addr,
  // data and busy pin
  output logic      [`FSP_DW-1:0] dq,
  output logic                    ready_busy_output
);
  // ====================
  // algorithm state, loaded by the bench
  int                 left = 0;
  logic               tmo = 0, abt = 0, ers = 0, susp = 0, t6 = 0, t2 = 0, d7 = 0;
  logic [`FSP_AW-1:0] sec = '0;
  logic [15:0]        last = 16'hFFFF;
  wire                busy = left > 0 || tmo || abt;
  wire                in_sec = ers && addr[`FSP_AW-1:SECT_SHIFT] == sec[`FSP_AW-1:SECT_SHIFT];

  // busy pin low while the algorithm runs or a timeout or abort flag is set, suspended counts as idle
  assign ready_busy_output = !busy;
  initial dq = 16'hFFFF;

  // start an algorithm: toggling reads left, error flags, erase sector, suspend
  task start(input int n, input logic to, ab, er, sp, input logic [`FSP_AW-1:0] s, input logic d);
    left = n;
    sec = s;
    {tmo, abt, ers, susp, d7} = {to, ab, er, sp, d};
  endtask : start

  // each read strobe: array data when idle outside a suspended erase sector, else the status word
  always @(negedge oe_n or negedge ce_n)
    if (!oe_n && !ce_n)
    begin
      if (busy)
        t6 = ~t6;
      if (in_sec && (busy || susp))
        t2 = ~t2;
      if (!busy && !(susp && in_sec))
        last = addr[15:0] ^ 16'h5A3C;
      else
        last = {~last[15:8], busy ? ~d7 & ~(ers & ~susp) : 1'b1, t6, tmo, ~last[4], ers, t2, abt,
                ~last[0]};
      if (left > 0)
        left--;
      dq = last;
    end

  // released bus shows the inverse, so a stale value never reads as good
  always @(posedge oe_n or posedge ce_n)
    dq = ~last;

  // a command write clears a failure at once; others are ignored while busy
  always @(posedge we_n)
    if (!ce_n && (tmo || abt))
    begin
      tmo = 0;
      abt = 0;
      left = 0;
    end
endmodule : fsp_flash_model

// ---- sim/test_flash_status_polling_bits.sv ----
// self-checking bench for the flash status polling host
`timescale 1ns/10ps
`include "fsp_cfg.svh"
module test_flash_status_polling_bits;
  import fsp_pkg::*;
  localparam logic [`FSP_AW-1:0] SEC = 26'h200_0000;
  logic               mclk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
  logic [7:0]         paddr = 8'h00;
  logic [31:0]        pwdata = 32'h0, prdata, st;
  logic               pready, pslverr, ce_n, oe_n, we_n, dq_oe_n, rb, e;
  logic [`FSP_AW-1:0] faddr, a;
  logic [`FSP_DW-1:0] dq_o, dq_i, fdq, rc, wd;
  int                 num_errors = 0, checks = 0, cyc = 0;

  // ====================
  // design, device model, shared data wire
  fsp_host dut_u (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n), .flash_addr(faddr),
    .flash_dq_o(dq_o), .flash_dq_oe_n(dq_oe_n), .flash_dq_i(dq_i), .ready_busy_output(rb));
  fsp_flash_model fl_u (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .addr(faddr), .dq(fdq),
    .ready_busy_output(rb));
  assign dq_i = dq_oe_n ? fdq : dq_o;

  // last word the host wrote into the part, caught as its write strobe rises
  always @(posedge we_n)
    if (!ce_n)
      wd <= dq_o;

  // clock, and a cycle ceiling against hangs
  initial forever #50 mclk = ~mclk;
  always @(posedge mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 6000)
    begin
      num_errors++;
      conclude();
    end
  end

  // ====================
  // tasks
  task automatic conclude;
    $display("checks %0d, mismatches %0d", checks, num_errors);
    if (num_errors == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : conclude

  task automatic chk(input logic [31:0] s, x);
    checks++;
    if (s !== x)
    begin
      num_errors++;
      $display("wrong value at %0t ns: saw %h, expected %h", $time, s, x);
    end
  endtask : chk

  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] d);
    @(posedge mclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, ad, d};
    @(posedge mclk);
    penable <= 1;
    do @(posedge mclk); while (pready !== 1'b1);
    st = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask : apb

  // launch one sequencer operation and wait until status shows idle
  task automatic run(input fsp_op_e op, input logic [`FSP_AW-1:0] ad);
    apb(1, `FSP_OFS_ADDR, 32'(ad));
    apb(1, `FSP_OFS_CTRL, {28'h0, op, 1'b1});
    do apb(0, `FSP_OFS_STAT, 32'h0); while (st[0] !== 1'b0);
  endtask : run

  // result code and masked status word of the last operation
  task automatic pchk(input fsp_res_e r, input logic [15:0] w, m);
    chk(32'(st[3:1]), 32'(r));
    chk(32'(st[23:8] & m), 32'(w));
  endtask : pchk

  function automatic logic [15:0] arr(input logic [`FSP_AW-1:0] ad);
    return ad[15:0] ^ 16'h5A3C;
  endfunction : arr

  // ====================
  // scenarios
  initial
  begin
    void'($urandom(30907));
    repeat (20) @(posedge mclk);
    reset <= 0;
    apb(0, `FSP_OFS_STAT, 32'h0);
    chk(st, 32'h20);
    apb(0, 8'h1C, 32'h0);
    chk({st[30:0], e}, 32'h1);
    $display("test done: registers");
    // program running: busy twice, then finished
    a = {1'b0, 25'($urandom)};
    fl_u.start(4, 0, 0, 0, 0, SEC, 1);
    run(OP_POLL, a);
    pchk(RES_BUSY, 16'h00, 16'hAA);
    chk(32'(st[5]), 32'h0);
    run(OP_POLL, a);
    run(OP_POLL, a);
    pchk(RES_PASS, arr(a) & 16'hAA, 16'hAA);
    $display("test done: program poll");
    // erase: inside and outside the sector, then no longer accepted
    fl_u.start(4, 0, 0, 1, 0, SEC, 0);
    run(OP_ERASE_CHK, SEC | 26'(a[15:0]));
    pchk(RES_BUSY, 16'h08, 16'hAA);
    chk(32'(st[5:4]), 32'h1);
    run(OP_ERASE_CHK, a);
    pchk(RES_BUSY, 16'h08, 16'hAA);
    run(OP_ERASE_CHK, a);
    pchk(RES_NOT_ACCEPTED, arr(a) & 16'hAA, 16'hAA);
    chk(32'(st[4]), 32'h0);
    $display("test done: erase check");
    // erase suspended: steady status inside, array data elsewhere
    fl_u.start(0, 0, 0, 1, 1, SEC, 0);
    run(OP_POLL, SEC);
    pchk(RES_PASS, 16'h88, 16'hAA);
    chk(32'(st[5]), 32'h1);
    repeat (3)
    begin
      a = {1'b0, 25'($urandom)};
      run(OP_READ, a);
      apb(0, `FSP_OFS_RDATA, 32'h0);
      chk(st, 32'(arr(a)));
    end
    $display("test done: erase suspend");
    // suspended program line is never read
    apb(1, `FSP_OFS_SUSP, {1'b1, 5'h0, a});
    run(OP_READ, a ^ 26'h5);
    pchk(RES_REFUSED, 16'h88, 16'hAA);
    apb(0, `FSP_OFS_RDATA, 32'h0);
    chk(st, 32'(arr(a)));
    apb(1, `FSP_OFS_SUSP, 32'h0);
    $display("test done: program suspend");
    // program inside erase suspend
    fl_u.start(4, 0, 0, 1, 1, SEC, 1);
    run(OP_POLL, a);
    pchk(RES_BUSY, 16'h00, 16'hA2);
    chk(32'(st[5]), 32'h0);
    run(OP_POLL, a);
    run(OP_POLL, a);
    pchk(RES_PASS, arr(a) & 16'hAA, 16'hAA);
    $display("test done: suspend program");
    // timeout: recheck, reset command, recovery
    rc = 16'($urandom);
    apb(1, `FSP_OFS_RSTCMD, {16'h0, rc});
    fl_u.start(2, 1, 0, 0, 0, SEC, 0);
    run(OP_POLL, a);
    pchk(RES_TIMEOUT, 16'h20, 16'h20);
    chk(32'(wd), 32'(rc));
    run(OP_POLL, a);
    pchk(RES_PASS, arr(a) & 16'hAA, 16'hAA);
    $display("test done: timeout");
    // buffer abort, then the abort reset write
    fl_u.start(0, 0, 1, 0, 0, SEC, 0);
    run(OP_POLL, a);
    pchk(RES_ABORT, 16'h02, 16'h02);
    apb(1, `FSP_OFS_WDATA, 32'h00F0);
    run(OP_WRITE, a);
    chk(32'(wd), 32'h00F0);
    run(OP_POLL, a);
    pchk(RES_PASS, arr(a) & 16'hAA, 16'hAA);
    $display("test done: abort");
    conclude();
  end
endmodule : test_flash_status_polling_bits
